/* core/ebt_pkg.sv */
package ebt_pkg;

   // ==========================================================
   // Register map (word index on the 3-bit register address)
   localparam logic [2:0] EBT_OFS_CTRL  = 3'h0;
   localparam logic [2:0] EBT_OFS_COUNT = 3'h1;
   localparam logic [2:0] EBT_OFS_CMP   = 3'h2;
   localparam logic [2:0] EBT_OFS_FLAG  = 3'h3;
   localparam logic [2:0] EBT_OFS_MASK  = 3'h4;

   // ==========================================================
   // Field positions and values
   localparam int         EBT_FORCE_BIT = 7;
   localparam int         EBT_OVF_BIT   = 0;
   localparam int         EBT_CMP_BIT   = 1;
   localparam logic [7:0] EBT_BOTTOM    = 8'h00;
   localparam logic [7:0] EBT_MAX       = 8'hFF;
   localparam logic [7:0] EBT_ZERO8     = 8'h00;
   localparam logic [1:0] EBT_MASK_RST  = 2'h0;

   // ==========================================================
   // Clock select codes and prescaler tap masks
   localparam logic [2:0] EBT_CS_STOP     = 3'h0;
   localparam logic [2:0] EBT_CS_DIV1     = 3'h1;
   localparam logic [2:0] EBT_CS_DIV8     = 3'h2;
   localparam logic [2:0] EBT_CS_DIV64    = 3'h3;
   localparam logic [2:0] EBT_CS_DIV256   = 3'h4;
   localparam logic [2:0] EBT_CS_DIV1024  = 3'h5;
   localparam logic [2:0] EBT_CS_EXT_FALL = 3'h6;
   localparam logic [2:0] EBT_CS_EXT_RISE = 3'h7;
   localparam logic [9:0] EBT_TAP8        = 10'h007;
   localparam logic [9:0] EBT_TAP64       = 10'h03F;
   localparam logic [9:0] EBT_TAP256      = 10'h0FF;
   localparam logic [9:0] EBT_TAP1024     = 10'h3FF;

   // ==========================================================
   // Compare output actions
   localparam logic [1:0] EBT_COM_OFF    = 2'h0;
   localparam logic [1:0] EBT_COM_TOGGLE = 2'h1;
   localparam logic [1:0] EBT_COM_CLEAR  = 2'h2;
   localparam logic [1:0] EBT_COM_SET    = 2'h3;

   typedef enum logic [1:0] {
      EBT_NORMAL = 2'h0,
      EBT_PHASE  = 2'h1,
      EBT_CTC    = 2'h2,
      EBT_FAST   = 2'h3
   } ebt_mode_t;

   typedef struct packed {
      logic       force_compare_strobe;
      logic       waveform_mode_low;
      logic [1:0] compare_output_mode;
      logic       waveform_mode_high;
      logic [2:0] clock_select;
   } ebt_ctrl_t;

   localparam ebt_ctrl_t EBT_CTRL_RST = 8'h00;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ebt_bus_t;

endpackage : ebt_pkg

/* core/ebt_timer.sv */
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
// Contract
// - Counter is 8 bits, bottom 00, max FF.
// - Top is FF or compare value per mode.
// - Clock select zero stops the counter.
// - Each timer tick clears, increments or decrements.
// - Processor reads and writes counter any time.
// - Processor counter write beats count or clear.
// - Comparator flags equality of counter and compare.
// - Match sets compare flag on next tick.
// - Compare request needs flag, enable, global enable.
// - Compare flag clears on service or write-one.
// - Overflow flag set per mode, requests interrupt.
// - Compare buffered in PWM, direct otherwise.
// - Buffer moves to active only at top/bottom.
// - Processor compare access hits buffer when buffered.
// - Force strobe acts like match, no flag; ignored in PWM modes.
// - Counter write blocks match on next tick.
// - Compare output state survives mode changes.
// - Output mode bits act immediately, unbuffered.
// - Requests visible in flag reg, individually masked.
// - Clock select picks source and active edge.
// - Codes 1..5 give divide 1,8,64,256,1024.
// - Codes 7/6 count rising/falling external edges.
// - Mode 0 counts up, wraps, overflow at zero.
// - Mode 2 clears counter on compare match.
module ebt_timer (
   input  wire logic             core_clk,
   input  wire logic             reset,
   input  wire ebt_pkg::ebt_bus_t bus_req,
   output logic [7:0]            rdata,
   input  wire logic             external_event_pin,
   input  wire logic             global_irq_enable,
   input  wire logic             compare_irq_ack,
   input  wire logic             overflow_irq_ack,
   output logic                  compare_output,
   output logic                  compare_irq,
   output logic                  overflow_irq
);

   // ==========================================================
   // Clock source selection
   function automatic logic ebt_sel_tick(
      input logic [2:0] cs,
      input logic [9:0] p,
      input logic       rise,
      input logic       fall
   );
      logic t;
      t = 1'h0;
      case (cs)
         ebt_pkg::EBT_CS_DIV1:
            t = 1'h1;
         ebt_pkg::EBT_CS_DIV8:
            t = (p & ebt_pkg::EBT_TAP8) == ebt_pkg::EBT_TAP8;
         ebt_pkg::EBT_CS_DIV64:
            t = (p & ebt_pkg::EBT_TAP64) == ebt_pkg::EBT_TAP64;
         ebt_pkg::EBT_CS_DIV256:
            t = (p & ebt_pkg::EBT_TAP256) == ebt_pkg::EBT_TAP256;
         ebt_pkg::EBT_CS_DIV1024:
            t = (p & ebt_pkg::EBT_TAP1024) == ebt_pkg::EBT_TAP1024;
         ebt_pkg::EBT_CS_EXT_FALL:
            t = fall;
         ebt_pkg::EBT_CS_EXT_RISE:
            t = rise;
         default:
            t = 1'h0;
      endcase
      return t;
   endfunction : ebt_sel_tick

   // PWM output action: clear mode drives hit_level, set mode its inverse
   function automatic logic ebt_pwm_act(
      input logic       cur,
      input logic [1:0] com,
      input logic       hit_level
   );
      logic v;
      v = cur;
      case (com)
         ebt_pkg::EBT_COM_CLEAR: v = hit_level;
         ebt_pkg::EBT_COM_SET:   v = ~hit_level;
         default:                v = cur;
      endcase
      return v;
   endfunction : ebt_pwm_act

   // ==========================================================
   // State
   ebt_pkg::ebt_ctrl_t ctrl_r;
   logic [7:0]         count_value_r;
   logic [7:0]         cmp_active_r;
   logic [7:0]         cmp_buf_r;
   logic [1:0]         mask_r;
   logic               cmp_flag_r;
   logic               ovf_flag_r;
   logic               block_r;
   logic               down_r;
   logic               oc_r;
   logic [9:0]         presc_r;
   logic               ext_meta_r;
   logic               ext_sync_r;
   logic               ext_prev_r;
   logic [7:0]         rdata_r;
   logic               cmp_irq_r;
   logic               ovf_irq_r;

   // ==========================================================
   // Bus decode
   wire wr_ctrl  = bus_req.wr && (bus_req.addr == ebt_pkg::EBT_OFS_CTRL);
   wire wr_cnt   = bus_req.wr && (bus_req.addr == ebt_pkg::EBT_OFS_COUNT);
   wire wr_cmp   = bus_req.wr && (bus_req.addr == ebt_pkg::EBT_OFS_CMP);
   wire wr_flag  = bus_req.wr && (bus_req.addr == ebt_pkg::EBT_OFS_FLAG);
   wire wr_mask  = bus_req.wr && (bus_req.addr == ebt_pkg::EBT_OFS_MASK);

   wire ebt_pkg::ebt_mode_t mode = ebt_pkg::ebt_mode_t'(
      {ctrl_r.waveform_mode_high, ctrl_r.waveform_mode_low});
   wire pwm = (mode == ebt_pkg::EBT_PHASE) || (mode == ebt_pkg::EBT_FAST);

   // ==========================================================
   // Timer clock enable
   wire ext_rise = ext_sync_r & ~ext_prev_r;
   wire ext_fall = ~ext_sync_r & ext_prev_r;
   // Stop code yields no tick at all
   wire timer_clock_enable = ebt_sel_tick(ctrl_r.clock_select, presc_r,
                                          ext_rise, ext_fall);

   // ==========================================================
   // Counter and compare
   wire at_max   = count_value_r == ebt_pkg::EBT_MAX;
   wire at_bot   = count_value_r == ebt_pkg::EBT_BOTTOM;
   wire match    = count_value_r == cmp_active_r;
   wire match_ok = match & ~block_r;
   // Dual slope turns round at max and at bottom
   wire phase_down = at_max | (down_r & ~at_bot);

   // Top is the compare value in mode 2, max elsewhere
   wire [7:0] count_step =
      ((mode == ebt_pkg::EBT_CTC) && match_ok)  ? ebt_pkg::EBT_BOTTOM :
      ((mode == ebt_pkg::EBT_FAST) && at_max)   ? ebt_pkg::EBT_BOTTOM :
      ((mode == ebt_pkg::EBT_PHASE) && phase_down) ?
         count_value_r - 8'h01 : count_value_r + 8'h01;

   // Processor write wins over any tick
   wire [7:0] count_nxt = wr_cnt ? bus_req.wdata :
                          timer_clock_enable ? count_step : count_value_r;
   // Blocking lasts until the next tick, even while stopped
   wire block_nxt = wr_cnt ? 1'h1 : timer_clock_enable ? 1'h0 : block_r;
   wire down_nxt  = (mode != ebt_pkg::EBT_PHASE) ? 1'h0 :
                    (timer_clock_enable && !wr_cnt) ? phase_down : down_r;

   // Buffer always follows writes; active copy follows only outside PWM
   wire top_load = pwm && timer_clock_enable && at_max;
   wire [7:0] cmp_buf_nxt = wr_cmp ? bus_req.wdata : cmp_buf_r;
   wire [7:0] cmp_active_nxt =
      (wr_cmp && !pwm) ? bus_req.wdata :
      top_load ? cmp_buf_r : cmp_active_r;

   // ==========================================================
   // Flags; a set in the same cycle as a clear wins
   wire cmp_set = timer_clock_enable && match_ok;
   // Overflow at max-to-zero, or at bottom in dual slope
   wire ovf_set = timer_clock_enable &&
                  ((mode == ebt_pkg::EBT_PHASE) ? at_bot : at_max);
   wire cmp_clr = (wr_flag && bus_req.wdata[ebt_pkg::EBT_CMP_BIT]) ||
                  compare_irq_ack;
   wire ovf_clr = (wr_flag && bus_req.wdata[ebt_pkg::EBT_OVF_BIT]) ||
                  overflow_irq_ack;
   wire cmp_flag_nxt = cmp_set | (cmp_flag_r & ~cmp_clr);
   wire ovf_flag_nxt = ovf_set | (ovf_flag_r & ~ovf_clr);

   // ==========================================================
   // Compare output; mode bits read live, never buffered
   wire [1:0] com = ctrl_r.compare_output_mode;
   wire force_hit = wr_ctrl && bus_req.wdata[ebt_pkg::EBT_FORCE_BIT] &&
                    !pwm;
   wire np_hit = cmp_set || force_hit;
   wire oc_np  = (com == ebt_pkg::EBT_COM_TOGGLE) ? ~oc_r :
                 (com == ebt_pkg::EBT_COM_CLEAR)  ? 1'h0 :
                 (com == ebt_pkg::EBT_COM_SET)    ? 1'h1 : oc_r;
   // Fast PWM: the bottom action wins when compare equals max
   wire oc_fast = !timer_clock_enable ? oc_r :
                  at_max ? ebt_pwm_act(oc_r, com, 1'h1) :
                  match_ok ? ebt_pwm_act(oc_r, com, 1'h0) : oc_r;
   wire oc_phase = cmp_set ? ebt_pwm_act(oc_r, com, phase_down) : oc_r;
   // No reset on mode change: only events move this state
   wire oc_nxt = (mode == ebt_pkg::EBT_FAST)  ? oc_fast :
                 (mode == ebt_pkg::EBT_PHASE) ? oc_phase :
                 np_hit ? oc_np : oc_r;

   // ==========================================================
   // Read mux; force bit always reads zero
   wire [7:0] rd_mux =
      (bus_req.addr == ebt_pkg::EBT_OFS_CTRL)  ? ctrl_r :
      (bus_req.addr == ebt_pkg::EBT_OFS_COUNT) ? count_value_r :
      (bus_req.addr == ebt_pkg::EBT_OFS_CMP)   ?
         (pwm ? cmp_buf_r : cmp_active_r) :
      (bus_req.addr == ebt_pkg::EBT_OFS_FLAG)  ?
         {6'h00, cmp_flag_r, ovf_flag_r} :
      (bus_req.addr == ebt_pkg::EBT_OFS_MASK)  ? {6'h00, mask_r} :
      ebt_pkg::EBT_ZERO8;
   wire [7:0] rdata_nxt = bus_req.rd ? rd_mux : ebt_pkg::EBT_ZERO8;

   wire ebt_pkg::ebt_ctrl_t ctrl_nxt = wr_ctrl ?
      {1'h0, bus_req.wdata[6:0]} : ctrl_r;
   wire [1:0] mask_nxt = wr_mask ? bus_req.wdata[1:0] : mask_r;

   // Requests masked individually and by the core's global enable
   wire cmp_irq_nxt = cmp_flag_r & mask_r[ebt_pkg::EBT_CMP_BIT] &
                      global_irq_enable;
   wire ovf_irq_nxt = ovf_flag_r & mask_r[ebt_pkg::EBT_OVF_BIT] &
                      global_irq_enable;

   // ==========================================================
   // Registers
   always_ff @(posedge core_clk) begin
      ext_meta_r <= external_event_pin;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ctrl_r        <= ebt_pkg::EBT_CTRL_RST;
         count_value_r <= ebt_pkg::EBT_ZERO8;
         cmp_active_r  <= ebt_pkg::EBT_ZERO8;
         cmp_buf_r     <= ebt_pkg::EBT_ZERO8;
         mask_r        <= ebt_pkg::EBT_MASK_RST;
         cmp_flag_r    <= 1'h0;
         ovf_flag_r    <= 1'h0;
         block_r       <= 1'h0;
         down_r        <= 1'h0;
         oc_r          <= 1'h0;
         presc_r       <= 10'h000;
         rdata_r       <= ebt_pkg::EBT_ZERO8;
         cmp_irq_r     <= 1'h0;
         ovf_irq_r     <= 1'h0;
      end else begin
         ctrl_r        <= ctrl_nxt;
         count_value_r <= count_nxt;
         cmp_active_r  <= cmp_active_nxt;
         cmp_buf_r     <= cmp_buf_nxt;
         mask_r        <= mask_nxt;
         cmp_flag_r    <= cmp_flag_nxt;
         ovf_flag_r    <= ovf_flag_nxt;
         block_r       <= block_nxt;
         down_r        <= down_nxt;
         oc_r          <= oc_nxt;
         presc_r       <= presc_r + 10'h001;
         rdata_r       <= rdata_nxt;
         cmp_irq_r     <= cmp_irq_nxt;
         ovf_irq_r     <= ovf_irq_nxt;
      end
   end

   assign rdata          = rdata_r;
   assign compare_output = oc_r;
   assign compare_irq    = cmp_irq_r;
   assign overflow_irq   = ovf_irq_r;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   a_stop_holds_count: assert property (
      (ctrl_r.clock_select == ebt_pkg::EBT_CS_STOP && !wr_cnt)
      |=> $stable(count_value_r))
      else $error("stopped counter moved");

   a_cpu_write_wins: assert property (
      wr_cnt |=> count_value_r == $past(bus_req.wdata))
      else $error("counter write lost");

   a_match_sets_flag: assert property (
      (timer_clock_enable && match && !block_r) |=> cmp_flag_r)
      else $error("match did not set flag");

   a_write_blocks_match: assert property (
      wr_cnt ##1 (timer_clock_enable && !wr_cnt && !cmp_flag_r)
      |=> !cmp_flag_r)
      else $error("blocked match set flag");

   a_flag_w1c_clear: assert property (
      (wr_flag && bus_req.wdata[ebt_pkg::EBT_CMP_BIT] && !cmp_set)
      |=> !cmp_flag_r)
      else $error("compare flag not cleared");

   a_irq_has_cause: assert property (
      compare_irq |-> $past(cmp_flag_r) &&
                      $past(mask_r[ebt_pkg::EBT_CMP_BIT]) &&
                      $past(global_irq_enable))
      else $error("compare request without cause");

   a_ovf_irq_cause: assert property (
      overflow_irq |-> $past(ovf_flag_r) &&
                       $past(mask_r[ebt_pkg::EBT_OVF_BIT]) &&
                       $past(global_irq_enable))
      else $error("overflow request without cause");

   a_normal_wrap_ovf: assert property (
      (mode == ebt_pkg::EBT_NORMAL && timer_clock_enable && at_max &&
       !wr_cnt && !wr_ctrl)
      |=> (count_value_r == ebt_pkg::EBT_BOTTOM) && ovf_flag_r)
      else $error("normal wrap wrong");

   a_ctc_clear_match: assert property (
      (mode == ebt_pkg::EBT_CTC && timer_clock_enable && match_ok &&
       !wr_cnt) |=> count_value_r == ebt_pkg::EBT_BOTTOM)
      else $error("no clear on match");

   a_phase_turns_max: assert property (
      (mode == ebt_pkg::EBT_PHASE && timer_clock_enable && at_max &&
       !wr_cnt) |=> count_value_r == $past(count_value_r) - 8'h01)
      else $error("dual slope did not turn at max");

   a_direct_cmp_write: assert property (
      (wr_cmp && !pwm) |=> cmp_active_r == $past(bus_req.wdata))
      else $error("direct compare write lost");

   a_buffer_holds: assert property (
      (wr_cmp && pwm && !top_load && !wr_ctrl) |=> $stable(cmp_active_r))
      else $error("buffered compare leaked");

   a_force_toggles: assert property (
      (force_hit && com == ebt_pkg::EBT_COM_TOGGLE && !cmp_set &&
       !cmp_flag_r && !cmp_clr)
      |=> (oc_r != $past(oc_r)) && !cmp_flag_r)
      else $error("force strobe misbehaved");

   a_div8_spacing: assert property (
      (ctrl_r.clock_select == ebt_pkg::EBT_CS_DIV8 && timer_clock_enable)
      |=> (!timer_clock_enable ||
           ctrl_r.clock_select != ebt_pkg::EBT_CS_DIV8) [*7])
      else $error("divide by 8 rate wrong");

   c_ctc_clear: cover property (
      mode == ebt_pkg::EBT_CTC && cmp_set);
   c_pwm_top_load: cover property (top_load && wr_cmp == 1'h0);
   c_overflow: cover property (ovf_set && overflow_irq_ack);
   c_ext_edge: cover property (
      ctrl_r.clock_select == ebt_pkg::EBT_CS_EXT_RISE && ext_rise);
   c_fast_bottom_set: cover property (
      mode == ebt_pkg::EBT_FAST && timer_clock_enable && at_max);

endmodule : ebt_timer

/* sim/ebt_core_model.sv */
`timescale 1ns/10ps
// ==========================================================
// Processor core side: register bus master and interrupt service
module ebt_core_model (
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic [7:0]  rdata,
   input  wire logic        compare_irq,
   input  wire logic        overflow_irq,
   output ebt_pkg::ebt_bus_t bus_req,
   output logic             global_irq_enable,
   output logic             compare_irq_ack,
   output logic             overflow_irq_ack
);
   logic service_en;

   initial begin
      bus_req           = '0;
      global_irq_enable = 1'b0;
      service_en        = 1'b0;
   end

   // Request lags its flag, so skip the cycle right after an ack
   always_ff @(posedge core_clk) begin
      if (reset) begin
         compare_irq_ack  <= 1'b0;
         overflow_irq_ack <= 1'b0;
      end else begin
         compare_irq_ack  <= service_en & compare_irq & ~compare_irq_ack;
         overflow_irq_ack <= service_en & overflow_irq & ~overflow_irq_ack;
      end
   end

   task automatic set_global(input logic en);
      @(posedge core_clk);
      global_irq_enable <= en;
   endtask : set_global

   // Leaving the strobe up lets the next access follow with no gap
   task automatic reg_wr(input logic [2:0] a, input logic [7:0] d,
                         input bit rel = 1'b1);
      @(posedge core_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      if (rel) begin
         @(posedge core_clk);
         bus_req <= '0;
      end
   endtask : reg_wr

   task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge core_clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      bus_req <= '0;
      #1;
      d = rdata;
   endtask : reg_rd
endmodule : ebt_core_model

/* sim/ebt_timer_test.sv */
`timescale 1ns/10ps
module ebt_timer_test;
   logic              core_clk = 1'b0;
   logic              reset = 1'b1;
   logic              external_event_pin = 1'b0;
   ebt_pkg::ebt_bus_t bus_req;
   logic [7:0]        rdata;
   logic              global_irq_enable;
   logic              compare_irq_ack;
   logic              overflow_irq_ack;
   logic              compare_output;
   logic              compare_irq;
   logic              overflow_irq;
   int                miscompares = 0;
   int                checks_done = 0;

   always #20 core_clk = ~core_clk;

   ebt_timer i_dut (.core_clk(core_clk), .reset(reset), .bus_req(bus_req),
      .rdata(rdata), .external_event_pin(external_event_pin),
      .global_irq_enable(global_irq_enable),
      .compare_irq_ack(compare_irq_ack), .overflow_irq_ack(overflow_irq_ack),
      .compare_output(compare_output), .compare_irq(compare_irq),
      .overflow_irq(overflow_irq));

   ebt_core_model i_cpu (.core_clk(core_clk), .reset(reset), .rdata(rdata),
      .compare_irq(compare_irq), .overflow_irq(overflow_irq),
      .bus_req(bus_req), .global_irq_enable(global_irq_enable),
      .compare_irq_ack(compare_irq_ack), .overflow_irq_ack(overflow_irq_ack));

   // ==========================================================
   // Helpers
   task automatic give_verdict();
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : give_verdict

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   function automatic logic [7:0] ctl(input logic [1:0] m,
      input logic [1:0] com, input logic [2:0] cs, input logic frc);
      ebt_pkg::ebt_ctrl_t c;
      c = '{force_compare_strobe: frc, waveform_mode_low: m[0],
            compare_output_mode: com, waveform_mode_high: m[1],
            clock_select: cs};
      return c;
   endfunction : ctl

   task automatic wr(input logic [2:0] a, input logic [7:0] d,
                     input bit rel = 1'b1);
      i_cpu.reg_wr(a, d, rel);
   endtask : wr

   task automatic rd_chk(input string what, input logic [2:0] a,
                         input logic [7:0] exp);
      logic [7:0] d;
      i_cpu.reg_rd(a, d);
      check(what, d, exp);
   endtask : rd_chk

   task automatic do_reset();
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
   endtask : do_reset

   // Exactly n clock edges with control c live lie between the two control writes
   task automatic run(input logic [7:0] c, input int n);
      wr(ebt_pkg::EBT_OFS_CTRL, c, n > 1);
      if (n > 1) repeat (n - 2) @(posedge core_clk);
      wr(ebt_pkg::EBT_OFS_CTRL, c & 8'hF8);
   endtask : run

   // Outputs are read 1 ns past the edge, once they have settled
   task automatic wait_irq(ref logic s, input logic lvl, input string what);
      int k;
      #1;
      for (k = 0; k < 6 && s !== lvl; k++) begin
         @(posedge core_clk);
         #1;
      end
      check(what, {7'h00, s}, {7'h00, lvl});
      if (s !== lvl) give_verdict();
   endtask : wait_irq

   // ==========================================================
   // Scenarios
   task automatic t_reset_and_stop();
      int a;
      do_reset();
      for (a = 0; a < 6; a++) rd_chk("reset reg", a[2:0], 8'h00);
      wr(ebt_pkg::EBT_OFS_COUNT, 8'h5A);
      repeat (10) @(posedge core_clk);
      rd_chk("stopped count", ebt_pkg::EBT_OFS_COUNT, 8'h5A);
      wr(3'h5, 8'hFF);
      rd_chk("unmapped", 3'h5, 8'h00);
      wr(ebt_pkg::EBT_OFS_CTRL, ctl(ebt_pkg::EBT_NORMAL, 2'h0, 3'h1, 1'b0), 0);
      wr(ebt_pkg::EBT_OFS_COUNT, 8'h40);
      wr(ebt_pkg::EBT_OFS_CTRL, 8'h00);
      rd_chk("write wins", ebt_pkg::EBT_OFS_COUNT, 8'h42);
   endtask : t_reset_and_stop

   task automatic t_normal_overflow();
      do_reset();
      wr(ebt_pkg::EBT_OFS_CMP, 8'h80);
      wr(ebt_pkg::EBT_OFS_COUNT, 8'hFD);
      wr(ebt_pkg::EBT_OFS_MASK, 8'h01);
      i_cpu.set_global(1'b1);
      run(ctl(ebt_pkg::EBT_NORMAL, 2'h0, 3'h1, 1'b0), 3);
      rd_chk("wrap", ebt_pkg::EBT_OFS_COUNT, 8'h00);
      rd_chk("ovf flag", ebt_pkg::EBT_OFS_FLAG, 8'h01);
      wait_irq(overflow_irq, 1'b1, "ovf irq");
      wr(ebt_pkg::EBT_OFS_FLAG, 8'h02);
      rd_chk("w1c other", ebt_pkg::EBT_OFS_FLAG, 8'h01);
      wr(ebt_pkg::EBT_OFS_FLAG, 8'h01);
      rd_chk("w1c ovf", ebt_pkg::EBT_OFS_FLAG, 8'h00);
      i_cpu.set_global(1'b0);
   endtask : t_normal_overflow

   task automatic t_ctc_irq();
      do_reset();
      wr(ebt_pkg::EBT_OFS_CMP, 8'h05);
      wr(ebt_pkg::EBT_OFS_MASK, 8'h02);
      run(ctl(ebt_pkg::EBT_CTC, 2'h0, 3'h1, 1'b0), 8);
      rd_chk("ctc count", ebt_pkg::EBT_OFS_COUNT, 8'h02);
      rd_chk("cmp flag", ebt_pkg::EBT_OFS_FLAG, 8'h02);
      rd_chk("direct cmp", ebt_pkg::EBT_OFS_CMP, 8'h05);
      check("no global", {7'h00, compare_irq}, 8'h00);
      i_cpu.set_global(1'b1);
      wait_irq(compare_irq, 1'b1, "cmp irq");
      wr(ebt_pkg::EBT_OFS_MASK, 8'h00);
      wait_irq(compare_irq, 1'b0, "masked");
      wr(ebt_pkg::EBT_OFS_MASK, 8'h02);
      i_cpu.service_en <= 1'b1;
      repeat (6) @(posedge core_clk);
      rd_chk("serviced", ebt_pkg::EBT_OFS_FLAG, 8'h00);
      i_cpu.service_en <= 1'b0;
      i_cpu.set_global(1'b0);
      // Counter written equal to compare on purpose: match must be lost
      wr(ebt_pkg::EBT_OFS_COUNT, 8'h05);
      run(ctl(ebt_pkg::EBT_CTC, 2'h0, 3'h1, 1'b0), 1);
      rd_chk("blocked", ebt_pkg::EBT_OFS_COUNT, 8'h06);
      rd_chk("no flag", ebt_pkg::EBT_OFS_FLAG, 8'h00);
   endtask : t_ctc_irq

   task automatic t_pwm_buffer();
      do_reset();
      wr(ebt_pkg::EBT_OFS_CTRL, ctl(ebt_pkg::EBT_FAST, 2'h0, 3'h0, 1'b0));
      wr(ebt_pkg::EBT_OFS_CMP, 8'h30);
      rd_chk("buffer read", ebt_pkg::EBT_OFS_CMP, 8'h30);
      wr(ebt_pkg::EBT_OFS_COUNT, 8'h2E);
      run(ctl(ebt_pkg::EBT_FAST, 2'h0, 3'h1, 1'b0), 4);
      rd_chk("held off", ebt_pkg::EBT_OFS_FLAG, 8'h00);
      wr(ebt_pkg::EBT_OFS_COUNT, 8'hFE);
      run(ctl(ebt_pkg::EBT_FAST, 2'h2, 3'h1, 1'b0), 2);
      rd_chk("fast wrap", ebt_pkg::EBT_OFS_COUNT, 8'h00);
      check("pwm set", {7'h00, compare_output}, 8'h01);
      wr(ebt_pkg::EBT_OFS_FLAG, 8'h03);
      wr(ebt_pkg::EBT_OFS_COUNT, 8'h2F);
      run(ctl(ebt_pkg::EBT_FAST, 2'h2, 3'h1, 1'b0), 2);
      rd_chk("after top", ebt_pkg::EBT_OFS_FLAG, 8'h02);
      check("pwm clear", {7'h00, compare_output}, 8'h00);
      do_reset();
      wr(ebt_pkg::EBT_OFS_COUNT, 8'hFD);
      run(ctl(ebt_pkg::EBT_PHASE, 2'h0, 3'h1, 1'b0), 4);
      rd_chk("dual slope", ebt_pkg::EBT_OFS_COUNT, 8'hFD);
   endtask : t_pwm_buffer

   task automatic t_force();
      do_reset();
      // Output state is set up by forcing, before anything drives a pin
      wr(ebt_pkg::EBT_OFS_CTRL, ctl(ebt_pkg::EBT_NORMAL, 2'h1, 3'h0, 1'b0));
      wr(ebt_pkg::EBT_OFS_CTRL, ctl(ebt_pkg::EBT_NORMAL, 2'h1, 3'h0, 1'b1));
      #1;
      check("force toggle", {7'h00, compare_output}, 8'h01);
      rd_chk("force no flag", ebt_pkg::EBT_OFS_FLAG, 8'h00);
      rd_chk("force count", ebt_pkg::EBT_OFS_COUNT, 8'h00);
      wr(ebt_pkg::EBT_OFS_CTRL, ctl(ebt_pkg::EBT_NORMAL, 2'h2, 3'h0, 1'b0), 0);
      wr(ebt_pkg::EBT_OFS_CTRL, ctl(ebt_pkg::EBT_NORMAL, 2'h2, 3'h0, 1'b1));
      #1;
      check("force clear", {7'h00, compare_output}, 8'h00);
      wr(ebt_pkg::EBT_OFS_CTRL, ctl(ebt_pkg::EBT_NORMAL, 2'h3, 3'h0, 1'b0), 0);
      wr(ebt_pkg::EBT_OFS_CTRL, ctl(ebt_pkg::EBT_NORMAL, 2'h3, 3'h0, 1'b1));
      wr(ebt_pkg::EBT_OFS_CTRL, ctl(ebt_pkg::EBT_FAST, 2'h0, 3'h0, 1'b0));
      wr(ebt_pkg::EBT_OFS_CTRL, ctl(ebt_pkg::EBT_PHASE, 2'h0, 3'h0, 1'b0));
      #1;
      check("kept state", {7'h00, compare_output}, 8'h01);
   endtask : t_force

   task automatic t_clock_sources();
      int cs_tab[5]  = '{1, 2, 3, 4, 5};
      int win_tab[5] = '{200, 1024, 1024, 1024, 1024};
      int exp_tab[5] = '{200, 128, 16, 4, 1};
      int i;
      for (i = 0; i < 5; i++) begin
         do_reset();
         run(ctl(ebt_pkg::EBT_NORMAL, 2'h0, cs_tab[i][2:0], 1'b0), win_tab[i]);
         rd_chk("prescale", ebt_pkg::EBT_OFS_COUNT, exp_tab[i][7:0]);
      end
      for (i = 7; i > 5; i--) begin
         do_reset();
         wr(ebt_pkg::EBT_OFS_CTRL, ctl(ebt_pkg::EBT_NORMAL, 2'h0, i[2:0], 1'b0));
         repeat (5) begin
            repeat (2) @(posedge core_clk);
            external_event_pin <= 1'b1;
            repeat (2) @(posedge core_clk);
            external_event_pin <= 1'b0;
         end
         repeat (6) @(posedge core_clk);
         rd_chk("ext edges", ebt_pkg::EBT_OFS_COUNT, 8'h05);
      end
   endtask : t_clock_sources

   initial begin
      #800000;
      miscompares++;
      $display("CHECK FAILED watchdog expected done seen hang");
      give_verdict();
   end

   initial begin
      t_reset_and_stop();
      t_normal_overflow();
      t_ctc_irq();
      t_pwm_buffer();
      t_force();
      t_clock_sources();
      give_verdict();
   end
endmodule : ebt_timer_test
